// file: dcd_decoder.sv
module dcd_decoder
  import dcd_pkg::*;
(
  // clock and resets
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_reset_n,
  // link pins
  input  wire logic              i_ck,
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic [BA_W-1:0]   i_ba,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_odt,
  // configuration
  input  wire logic              i_org_x16,
  input  wire logic [1:0]        i_bl_mode,
  // decoded command
  output logic                   o_cmd_valid,
  output dcd_cmd_t               o_cmd,
  output logic [BA_W-1:0]        o_bank,
  output logic [BA_W-1:0]        o_mr_sel,
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_auto_pre,
  output logic                   o_bc4,
  output logic                   o_refresh,
  // status
  output dcd_pwr_t               o_pwr_state,
  output logic                   o_burst_busy,
  output logic                   o_odt_en
);

  // ***************************************************************
  // reset and pin synchronisation
  // ***************************************************************
  localparam int PIN_W = 7 + BA_W + ADDR_W;

  logic                  rst_any;
  logic [PIN_W-1:0]      pins_s;
  logic                  ck_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s;
  logic [BA_W-1:0]       ba_s;
  logic [ADDR_W-1:0]     addr_s;
  logic                  ck_d;
  logic                  ck_rise;
  logic                  cke_prev;
  dcd_cmd_t              dec;
  logic [2:0]            burst_cnt;
  logic [2:0]            next_burst;

  // either reset source clears at once, no clock needed
  assign rst_any = i_rst | ~i_reset_n;

  dcd_sync #(.W(PIN_W)) i_dcd_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (rst_any),
    .i_d       ({i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_odt, i_ba, i_addr}),
    .o_q       (pins_s)
  );

  assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, addr_s} = pins_s;

  // link clock edge finder; pins are settled long before the edge
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
    end
  end

  assign ck_rise = ck_s & ~ck_d;

  // ***************************************************************
  // command decode
  // ***************************************************************
  // strobes, clock enable and the auto-precharge address bit only; odt and other address bits never steer the code
  function automatic dcd_cmd_t decode_cmd(input logic cke_p, input logic cke_c, input logic cs_n,
                                          input logic ras_n, input logic cas_n, input logic we_n,
                                          input logic ap);
    dcd_cmd_t c;
    logic [2:0] s;
    c = CMD_ILLEGAL;
    s = {ras_n, cas_n, we_n};
    if (cke_p && cke_c) begin
      if (cs_n) begin
        c = CMD_NOP;
      end else begin
        case (s)
          3'h0:    c = CMD_MRS;
          3'h1:    c = CMD_REF;
          3'h2:    c = ap ? CMD_PREA : CMD_PRE;
          3'h3:    c = CMD_ACT;
          3'h4:    c = CMD_WR;
          3'h5:    c = CMD_RD;
          3'h6:    c = ap ? CMD_ZQCL : CMD_ZQCS;
          3'h7:    c = CMD_NOP;
          default: c = CMD_ILLEGAL;
        endcase
      end
    end else if (cke_p && !cke_c) begin
      if (!cs_n && s == 3'h1) begin
        c = CMD_SRE;
      end else if (cs_n || s == 3'h7) begin
        c = CMD_PDE;
      end
    end else if (!cke_p && cke_c) begin
      if (cs_n || s == 3'h7) begin
        c = CMD_PDX;
      end
    end else begin
      c = CMD_NOP;
    end
    return c;
  endfunction

  // chop-4 length: fixed chop, or on the fly with the chop bit low
  function automatic logic is_chop(input logic [1:0] mode, input logic bl8_sel);
    return (mode == BLM_FIX4) || (mode == BLM_OTF && !bl8_sel);
  endfunction

  assign dec = decode_cmd(cke_prev, cke_s, cs_s, ras_s, cas_s, we_s, addr_s[AP_BIT]);

  // previous clock enable level, taken at each link rising edge
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      cke_prev <= 1'b0;
    end else if (ck_rise || (o_pwr_state == PWR_SREF && cke_s)) begin
      cke_prev <= cke_s;
    end
  end

  // command strobe and code, one system cycle after the link edge
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      o_cmd_valid <= 1'b0;
      o_cmd       <= CMD_NOP;
      o_refresh   <= 1'b0;
    end else begin
      o_cmd_valid <= ck_rise && o_pwr_state != PWR_SREF;
      o_cmd       <= ck_rise ? dec : o_cmd;
      // refresh only from the active state, never in power-down
      o_refresh   <= ck_rise && dec == CMD_REF && o_pwr_state == PWR_ACTIVE;
    end
  end

  // address fields; deselect and no-operation leave them alone
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      o_bank     <= '0;
      o_mr_sel   <= '0;
      o_addr     <= '0;
      o_auto_pre <= 1'b0;
      o_bc4      <= 1'b0;
    end else if (ck_rise) begin
      if (dec == CMD_MRS) begin
        o_mr_sel <= ba_s;
      end
      if (dec inside {CMD_PRE, CMD_ACT, CMD_WR, CMD_RD}) begin
        o_bank <= ba_s;
      end
      if (dec == CMD_ACT) begin
        o_addr              <= addr_s;
        o_addr[ROW_TOP_BIT] <= addr_s[ROW_TOP_BIT] & ~i_org_x16;
      end
      if (dec == CMD_WR || dec == CMD_RD) begin
        o_addr     <= {{(ADDR_W-COL_W){1'b0}}, addr_s[COL_W-1:0]};
        o_auto_pre <= addr_s[AP_BIT];
        // fixed modes ignore the chop bit
        o_bc4      <= is_chop(i_bl_mode, addr_s[BC_BIT]);
      end
    end
  end

  // ***************************************************************
  // burst tracking
  // ***************************************************************
  // counts link edges; only its own end or a seamless follow-on reloads it
  always_comb begin
    next_burst = burst_cnt;
    if (ck_rise && burst_cnt != BURST_IDLE) begin
      next_burst = burst_cnt - 3'h1;
    end
    if (ck_rise && (dec == CMD_WR || dec == CMD_RD) && burst_cnt <= 3'h1) begin
      next_burst = is_chop(i_bl_mode, addr_s[BC_BIT]) ? BURST_CK4 : BURST_CK8;
    end
  end

  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      burst_cnt <= BURST_IDLE;
    end else begin
      burst_cnt <= next_burst;
    end
  end

  assign o_burst_busy = burst_cnt != BURST_IDLE;

  // ***************************************************************
  // power state
  // ***************************************************************
  // self refresh exit follows the clock enable level, not a link edge
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      o_pwr_state <= PWR_ACTIVE;
    end else begin
      case (o_pwr_state)
        PWR_ACTIVE: begin
          if (ck_rise && dec == CMD_SRE) begin
            o_pwr_state <= PWR_SREF;
          end else if (ck_rise && dec == CMD_PDE) begin
            o_pwr_state <= PWR_PDOWN;
          end
        end
        PWR_PDOWN: begin
          if (ck_rise && dec == CMD_PDX) begin
            o_pwr_state <= PWR_ACTIVE;
          end
        end
        PWR_SREF: begin
          if (cke_s) begin
            o_pwr_state <= PWR_ACTIVE;
          end
        end
        default: o_pwr_state <= PWR_ACTIVE;
      endcase
    end
  end

  // termination follows its pin except in self refresh
  always_ff @(posedge i_clk_sys or posedge rst_any) begin
    if (rst_any) begin
      o_odt_en <= 1'b0;
    end else begin
      o_odt_en <= odt_s && o_pwr_state != PWR_SREF &&
                  !(o_pwr_state == PWR_ACTIVE && ck_rise && dec == CMD_SRE);
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (rst_any);

  AST_DECODE_AT_EDGE: assert property (o_cmd_valid |-> $past(ck_rise))
    else $error("command strobe without link clock edge");
  AST_ROW_TOP_MASK: assert property (ck_rise && dec == CMD_ACT && i_org_x16 |=> !o_addr[ROW_TOP_BIT])
    else $error("top row bit kept in x16 organisation");
  AST_MR_SELECT: assert property (ck_rise && dec == CMD_MRS |=> o_mr_sel == $past(ba_s))
    else $error("mode register select not taken from bank lines");
  AST_BURST_RUNS: assert property ($rose(o_burst_busy) |-> o_burst_busy [*8])
    else $error("burst ended early");
  AST_NOP_KEEPS_BURST: assert property (ck_rise && dec == CMD_NOP && burst_cnt > 3'h1 |=> o_burst_busy)
    else $error("no-operation stopped a burst");
  AST_DESELECT_IS_NOP: assert property (ck_rise && cs_s && cke_s && cke_prev |=>
    o_cmd == CMD_NOP && $stable(o_addr))
    else $error("deselect not treated as no-operation");
  AST_NO_REFRESH_PD: assert property (o_pwr_state == PWR_PDOWN |-> !o_refresh)
    else $error("refresh in power-down");
  AST_ODT_OFF_SREF: assert property (o_pwr_state == PWR_SREF |=> !o_odt_en)
    else $error("termination active in self refresh");
  AST_SRX_ASYNC: assert property (o_pwr_state == PWR_SREF && cke_s |=> o_pwr_state == PWR_ACTIVE)
    else $error("self refresh exit waited for link clock");
  AST_AUTO_PRE: assert property (ck_rise && (dec == CMD_WR || dec == CMD_RD) |=>
    o_auto_pre == $past(addr_s[AP_BIT]))
    else $error("auto precharge flag wrong");
  AST_FIXED_IGNORES_BC: assert property (ck_rise && dec == CMD_RD && i_bl_mode == BLM_FIX8 |=> !o_bc4)
    else $error("fixed burst mode used chop bit");

  COV_WRITE: cover property (o_cmd_valid && o_cmd == CMD_WR);
  COV_SREF_ROUND: cover property (o_pwr_state == PWR_SREF ##[1:1000] o_pwr_state == PWR_ACTIVE);
  COV_PDOWN: cover property (o_pwr_state == PWR_PDOWN);

endmodule

// file: dcd_pkg.sv
package dcd_pkg;

  // ***************************************************************
  // command codes and power states
  // ***************************************************************
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PRE, CMD_PREA, CMD_ACT,
    CMD_WR, CMD_RD, CMD_PDE, CMD_PDX, CMD_ZQCL, CMD_ZQCS, CMD_ILLEGAL
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PDOWN, PWR_SREF
  } dcd_pwr_t;

  // ***************************************************************
  // widths, field positions, burst figures
  // ***************************************************************
  localparam int          BA_W        = 3;
  localparam int          ADDR_W      = 16;
  localparam int          COL_W       = 10;
  localparam int          AP_BIT      = 10;
  localparam int          BC_BIT      = 12;
  localparam int          ROW_TOP_BIT = 15;
  localparam logic [1:0]  BLM_FIX8    = 2'h0;
  localparam logic [1:0]  BLM_OTF     = 2'h1;
  localparam logic [1:0]  BLM_FIX4    = 2'h2;
  // burst duration in link clock rising edges (8 beats, 4 beats)
  localparam logic [2:0]  BURST_CK8   = 3'h4;
  localparam logic [2:0]  BURST_CK4   = 3'h2;
  localparam logic [2:0]  BURST_IDLE  = 3'h0;

endpackage

// file: dcd_sync.sv
// two-stage synchroniser for a bundle of pin inputs
module dcd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // pins and synchronised copy
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// file: dcd_ctrl_model.sv
// ***************************************************************
// controller side of the command bus
// ***************************************************************
module dcd_ctrl_model (
  // bench clock, used only to time pin changes
  input  wire logic        i_clk_sys,
  // command bus pins
  output logic             o_ck,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [2:0]       o_ba,
  output logic [15:0]      o_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus carries a no-operation with the link clock parked low
  initial begin
    o_ck    = 1'b0;
    o_cke   = 1'b1;
    o_cs_n  = 1'b0;
    o_ras_n = 1'b1;
    o_cas_n = 1'b1;
    o_we_n  = 1'b1;
    o_ba    = 3'h0;
    o_addr  = 16'h0000;
  end

  // one link clock cycle of 125 ns; pins settle 62.5 ns before the rise
  task automatic issue(input logic c, input logic [3:0] s, input logic [2:0] b, input logic [15:0] a);
    @(negedge i_clk_sys);
    o_cke                     = c;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = s;
    if (s[3]) begin
      // deselected: address lines flip so a stale copy never looks valid
      o_ba   = ~o_ba;
      o_addr = ~o_addr;
    end else begin
      o_ba   = b;
      o_addr = a;
    end
    #62.5 o_ck = 1'b1;
    #62.5 o_ck = 1'b0;
  endtask

  // self refresh exit: clock enable rises while the link clock stands still
  task automatic wake();
    @(negedge i_clk_sys);
    o_cke = 1'b1;
  endtask
endmodule

// file: tb_dcd_decoder.sv
module tb_dcd_decoder
  import dcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ***************************************************************
  // signals, instances, clock
  // ***************************************************************
  logic        clk;
  logic        rst;
  logic        reset_n;
  logic        odt;
  logic        org_x16;
  logic [1:0]  bl_mode;
  wire logic   ck, cke, cs_n, ras_n, cas_n, we_n;
  wire logic [2:0]  ba;
  wire logic [15:0] addr;
  logic        cmd_valid, auto_pre, bc4, refresh, busy, odt_en;
  dcd_cmd_t    cmd;
  dcd_pwr_t    pwr;
  logic [2:0]  bank, mr_sel;
  logic [15:0] q_addr;
  int          n_fail, n_checks, n_valid, n_ref, v, r;

  dcd_ctrl_model i_dcd_ctrl_model (.i_clk_sys(clk), .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));

  dcd_decoder i_dcd_decoder (.i_clk_sys(clk), .i_rst(rst), .i_reset_n(reset_n), .i_ck(ck), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_odt(odt),
    .i_org_x16(org_x16), .i_bl_mode(bl_mode), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_bank(bank),
    .o_mr_sel(mr_sel), .o_addr(q_addr), .o_auto_pre(auto_pre), .o_bc4(bc4), .o_refresh(refresh),
    .o_pwr_state(pwr), .o_burst_busy(busy), .o_odt_en(odt_en));

  // free-running 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pulse counters, since the strobes stand for one cycle only
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_valid++;
    if (refresh === 1'b1) n_ref++;
  end

  // ***************************************************************
  // checking and access tasks
  // ***************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask

  // one command, exactly one decode strobe expected for it
  task automatic cmd_chk(input logic c, input logic [3:0] s, input logic [2:0] b, input logic [15:0] a,
                         input dcd_cmd_t e);
    v = n_valid;
    i_dcd_ctrl_model.issue(c, s, b, a);
    chk(16'(n_valid - v), 16'h0001);
    chk(16'(cmd), 16'(e));
  endtask

  task automatic nops(input int n);
    repeat (n) i_dcd_ctrl_model.issue(1'b1, 4'h7, 3'h0, 16'h0000);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  logic [3:0]  ts [6] = '{4'h2, 4'h2, 4'h6, 4'h6, 4'h7, 4'h8};
  logic [15:0] ta [6] = '{16'h0000, 16'h0400, 16'h0400, 16'h0000, 16'h0000, 16'h0000};
  dcd_cmd_t    te [6] = '{CMD_PRE, CMD_PREA, CMD_ZQCL, CMD_ZQCS, CMD_NOP, CMD_NOP};

  initial begin
    rst     = 1'b1;
    reset_n = 1'b1;
    odt     = 1'b1;
    org_x16 = 1'b0;
    bl_mode = BLM_OTF;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    nops(1); // first edge after reset may read as power-down exit
    cmd_chk(1'b1, 4'h0, 3'h3, 16'h0000, CMD_MRS);
    chk(16'(mr_sel), 16'h0003);
    // own snapshot: cmd_chk reuses v for the strobe count
    r = n_ref;
    cmd_chk(1'b1, 4'h1, 3'h0, 16'h0000, CMD_REF);
    chk(16'(n_ref - r), 16'h0001);
    // termination toggles between commands and must not disturb decode
    for (int i = 0; i < 6; i++) begin
      @(negedge clk) odt = i[0];
      cmd_chk(1'b1, ts[i], 3'h6, ta[i], te[i]);
      chk(16'(odt_en), 16'(odt));
    end
    cmd_chk(1'b1, 4'h3, 3'h5, 16'h8123, CMD_ACT);
    chk(16'(bank), 16'h0005);
    chk(q_addr, 16'h8123);
    @(negedge clk) org_x16 = 1'b1;
    cmd_chk(1'b1, 4'h3, 3'h5, 16'h8123, CMD_ACT);
    chk(q_addr, 16'h0123);
    @(negedge clk) org_x16 = 1'b0;
    $display("test decode done");
    cmd_chk(1'b1, 4'h4, 3'h2, 16'h05a5, CMD_WR);
    chk({bank, auto_pre, bc4, busy}, {3'h2, 3'h7});
    chk(q_addr, 16'h01a5);
    nops(1);
    chk(16'(busy), 16'h0001);
    nops(1);
    chk(16'(busy), 16'h0000);
    cmd_chk(1'b1, 4'h5, 3'h1, 16'h1003, CMD_RD);
    chk({bank, auto_pre, bc4}, {3'h1, 2'h0});
    nops(2);
    cmd_chk(1'b1, 4'h4, 3'h4, 16'h1000, CMD_WR);
    chk(16'(busy), 16'h0001);
    nops(2);
    chk(16'(busy), 16'h0000);
    @(negedge clk) bl_mode = BLM_FIX8;
    cmd_chk(1'b1, 4'h5, 3'h0, 16'h0000, CMD_RD);
    chk(16'(bc4), 16'h0000);
    @(negedge clk) bl_mode = BLM_FIX4;
    cmd_chk(1'b1, 4'h5, 3'h0, 16'h1000, CMD_RD);
    chk(16'(bc4), 16'h0001);
    @(negedge clk) bl_mode = BLM_OTF;
    nops(4);
    $display("test bursts done");
    cmd_chk(1'b0, 4'h3, 3'h0, 16'h0000, CMD_ILLEGAL);
    nops(2);
    cmd_chk(1'b0, 4'h7, 3'h0, 16'h0000, CMD_PDE);
    chk(16'(pwr), 16'(PWR_PDOWN));
    v = n_ref;
    i_dcd_ctrl_model.issue(1'b0, 4'h1, 3'h0, 16'h0000);
    chk(16'(n_ref - v), 16'h0000);
    cmd_chk(1'b1, 4'h7, 3'h0, 16'h0000, CMD_PDX);
    chk(16'(pwr), 16'(PWR_ACTIVE));
    cmd_chk(1'b0, 4'h1, 3'h0, 16'h0000, CMD_SRE);
    chk({14'h0000, pwr}, 16'(PWR_SREF));
    @(negedge clk) odt = 1'b1;
    repeat (6) @(posedge clk);
    chk(16'(odt_en), 16'h0000);
    i_dcd_ctrl_model.wake();
    repeat (6) @(posedge clk);
    chk(16'(pwr), 16'(PWR_ACTIVE));
    nops(2);
    cmd_chk(1'b0, 4'h7, 3'h0, 16'h0000, CMD_PDE);
    @(negedge clk) reset_n = 1'b0;
    #1 chk({pwr, 4'(cmd)}, {2'(PWR_ACTIVE), 4'(CMD_NOP)});
    repeat (2) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    nops(1);
    cmd_chk(1'b1, 4'h7, 3'h0, 16'h0000, CMD_NOP);
    $display("test power done");
    test_done();
  end
endmodule
